// *** hdl/ext_port_regs.svh ***
/*
  register offsets, field positions, reset values and address pages of the boot-space external port.
  assumes an Avalon-MM slave with 32-bit data and word-aligned byte addresses.
*/
`ifndef EXT_PORT_REGS_SVH
`define EXT_PORT_REGS_SVH

// register byte addresses
`define OFS_EMI_CTL 6'h00
`define OFS_BANK_CTL 6'h04
`define OFS_BOOT_CTL 6'h08
`define OFS_IO_CTL 6'h0C
`define OFS_BRIDGE_STAT 6'h10
`define OFS_EXCHANGE 6'h14

// interface control fields
`define EMI_BUS16_BIT 0
`define EMI_RD_NEG_BIT 4
`define EMI_WR_NEG_BIT 5
`define EMI_LOCK_BIT 8
`define EMI_CTL_RST 16'h0000

// access control fields: [3:0] rd waits, [7:4] wr waits, [8] wait mode,
// [10:9] clock divider, [11] write hold, [12] common select enable
`define ACC_RDW_LSB 0
`define ACC_WRW_LSB 4
`define ACC_WMODE_BIT 8
`define ACC_DIV_LSB 9
`define ACC_HOLD_BIT 11
`define ACC_CMS_BIT 12
`define ACC_CTL_RST 16'h0000

// bridge status fields
`define BRG_PMBOOT_BIT 1
`define BRG_W24_BIT 3
`define BRG_STAT_RST 16'h0000

// address spaces (upper address bits of the core address)
`define BOOT_PAGE 8'h80
`define IO_PAGE 8'h40

`endif

// *** hdl/ext_port_pkg.sv ***
/*
  types of the boot-space external port.
  assumes ext_port_regs.svh for all numeric constants.
*/
package ext_port_pkg;
  // gray-coded along idle, setup, strobe, next
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b11,
    ST_NEXT = 2'b10
  } port_state_t;
  typedef enum logic [1:0] {SP_BANK = 2'b00, SP_BOOT = 2'b01, SP_IO = 2'b10} space_t;
  typedef enum logic [1:0] {SRC_INSTR = 2'b00, SRC_DATA = 2'b01, SRC_DMA = 2'b10} source_t;
endpackage : ext_port_pkg

// *** hdl/space_clock_div.sv ***
/*
  per-space clock divider: emits a one-cycle tick every (div+1) cycles.
  assumes div is steady while run is high.
*/
module space_clock_div (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_run,
  input wire logic [1:0] i_div,
  // tick
  output logic o_tick
);
  logic [1:0] count;

  // restart on idle so every access begins aligned
  always_ff @(posedge i_clk) begin
    if (i_srst || !i_run || count == i_div) begin
      count <= 2'h0;
    end else begin
      count <= count + 2'h1;
    end
  end
  assign o_tick = i_run && (count == i_div);
endmodule : space_clock_div

// *** hdl/boot_space_external_port.sv ***
/*
  boot-space external port: register slave, request arbitration, address translation,
  byte packing and asynchronous memory strobes.
  assumes requesters hold a request until done; memory is asynchronous with fixed wait counts.
*/
// Decided for this implementation: register access over Avalon-MM and the address map.
`include "ext_port_regs.svh"

module boot_space_external_port
  import ext_port_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // avalon-mm register slave
  input wire logic [5:0] i_AVS_ADDRESS,
  input wire logic i_AVS_READ,
  input wire logic i_AVS_WRITE,
  input wire logic [31:0] i_AVS_WRITEDATA,
  input wire logic [3:0] i_AVS_BYTEENABLE,
  output logic [31:0] o_AVS_READDATA,
  output logic o_AVS_WAITREQUEST,
  // requesters: 0 instruction, 1 data, 2 dma
  input wire logic [2:0] i_REQ,
  input wire logic [2:0] i_REQ_WRITE,
  input wire logic [2:0] i_REQ_W24,
  input wire logic [2:0] i_REQ_SECOND_GEN,
  input wire logic [23:0] i_REQ_ADDR0,
  input wire logic [23:0] i_REQ_ADDR1,
  input wire logic [23:0] i_REQ_ADDR2,
  input wire logic [23:0] i_REQ_WDATA0,
  input wire logic [23:0] i_REQ_WDATA1,
  input wire logic [23:0] i_REQ_WDATA2,
  output logic [2:0] o_REQ_DONE,
  output logic [15:0] o_RDATA_HIGH,
  output logic [7:0] o_BUS_EXCHANGE,
  // external memory pins
  output logic [23:0] o_EXT_ADDR,
  input wire logic [15:0] i_EXT_DATA,
  output logic [15:0] o_EXT_DATA,
  output logic o_EXT_DATA_OE,
  output logic o_RD_STROBE,
  output logic o_WR_STROBE,
  output logic o_BOOT_SPACE_SELECT_N,
  output logic o_BANK_SELECT_N,
  output logic o_IO_SELECT_N,
  output logic o_COMMON_SELECT_OUTPUT
);
  // registers
  logic [15:0] ext_mem_if_control;
  logic [15:0] bank_space_access_control;
  logic [15:0] boot_space_access_control;
  logic [15:0] io_space_access_control;
  logic [15:0] bridge_stat;
  logic [7:0] bus_exchange_reg;
  // access state
  port_state_t state;
  port_state_t next_state;
  space_t space;
  logic [1:0] grant;
  logic acc_write;
  logic acc_w24;
  logic [23:0] byte_addr;
  logic [23:0] wdata;
  logic [23:0] rdata;
  logic [1:0] beat;
  logic [1:0] last_beat;
  logic [3:0] wait_cnt;
  logic [15:0] din_q;
  logic rd_pend;
  logic [15:0] din_s1;
  logic [15:0] din_s2;
  logic [15:0] din_s3;

  // space decode, used for the request and for the register select
  function automatic space_t decode_space(input logic [23:0] a, input logic sec_gen, input logic [15:0] brg);
    if (sec_gen && brg[`BRG_PMBOOT_BIT] && brg[`BRG_W24_BIT]) begin
      decode_space = SP_BOOT;
    end else if (a[23:16] == `BOOT_PAGE) begin
      decode_space = SP_BOOT;
    end else if (a[23:16] == `IO_PAGE) begin
      decode_space = SP_IO;
    end else begin
      decode_space = SP_BANK;
    end
  endfunction : decode_space

  function automatic logic [15:0] space_ctl(input space_t s, input logic [15:0] bk, input logic [15:0] bt,
                                            input logic [15:0] io);
    unique case (s)
      SP_BOOT: space_ctl = bt;
      SP_IO: space_ctl = io;
      default: space_ctl = bk;
    endcase
  endfunction : space_ctl

  // register bus decode
  wire busy = (state != ST_IDLE);
  wire bus16 = ext_mem_if_control[`EMI_BUS16_BIT];
  wire locked = ext_mem_if_control[`EMI_LOCK_BIT];
  wire wr_emi = i_AVS_WRITE && i_AVS_ADDRESS == `OFS_EMI_CTL;
  wire wr_bank = i_AVS_WRITE && i_AVS_ADDRESS == `OFS_BANK_CTL && !locked;
  wire wr_boot = i_AVS_WRITE && i_AVS_ADDRESS == `OFS_BOOT_CTL && !locked;
  wire wr_io = i_AVS_WRITE && i_AVS_ADDRESS == `OFS_IO_CTL && !locked;
  wire wr_brg = i_AVS_WRITE && i_AVS_ADDRESS == `OFS_BRIDGE_STAT;
  wire [15:0] wmask = {{8{i_AVS_BYTEENABLE[1]}}, {8{i_AVS_BYTEENABLE[0]}}};
  wire [15:0] wval = i_AVS_WRITEDATA[15:0];
  // size and polarity bits are frozen while locked or busy
  wire [15:0] emi_keep = (locked || busy) ? 16'h0031 : 16'h0000;
  wire [15:0] emi_mask = wmask & ~emi_keep;

  // reads wait one cycle so the registered data stands when waitrequest drops
  assign o_AVS_WAITREQUEST = i_AVS_READ && !rd_pend;

  // register writes with byte enables
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      ext_mem_if_control <= `EMI_CTL_RST;
      bank_space_access_control <= `ACC_CTL_RST;
      boot_space_access_control <= `ACC_CTL_RST;
      io_space_access_control <= `ACC_CTL_RST;
      bridge_stat <= `BRG_STAT_RST;
    end else begin
      if (wr_emi) begin
        ext_mem_if_control <= (ext_mem_if_control & ~emi_mask) | (wval & emi_mask);
      end
      if (wr_bank) begin
        bank_space_access_control <= (bank_space_access_control & ~wmask) | (wval & wmask);
      end
      if (wr_boot) begin
        boot_space_access_control <= (boot_space_access_control & ~wmask) | (wval & wmask);
      end
      if (wr_io) begin
        io_space_access_control <= (io_space_access_control & ~wmask) | (wval & wmask);
      end
      if (wr_brg) begin
        bridge_stat <= (bridge_stat & ~wmask) | (wval & wmask);
      end
    end
  end

  // read mux; unmapped offsets read zero
  wire [15:0] rd_mux = (i_AVS_ADDRESS == `OFS_EMI_CTL) ? ext_mem_if_control :
                       (i_AVS_ADDRESS == `OFS_BANK_CTL) ? bank_space_access_control :
                       (i_AVS_ADDRESS == `OFS_BOOT_CTL) ? boot_space_access_control :
                       (i_AVS_ADDRESS == `OFS_IO_CTL) ? io_space_access_control :
                       (i_AVS_ADDRESS == `OFS_BRIDGE_STAT) ? {bridge_stat[15:3], busy, bridge_stat[1:0]} :
                       (i_AVS_ADDRESS == `OFS_EXCHANGE) ? {8'h00, bus_exchange_reg} : 16'h0000;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      o_AVS_READDATA <= 32'h0000_0000;
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= i_AVS_READ && !rd_pend;
      if (i_AVS_READ && !rd_pend) begin
        o_AVS_READDATA <= {16'h0000, rd_mux};
      end
    end
  end

  // fixed priority: dma, data, instruction
  // a requester whose done pulse is out is not granted again in that cycle
  wire [2:0] req_live = i_REQ & ~o_REQ_DONE;
  wire [1:0] pick = req_live[2] ? 2'd2 : (req_live[1] ? 2'd1 : 2'd0);
  wire [23:0] pick_addr = (pick == 2'd2) ? i_REQ_ADDR2 : (pick == 2'd1) ? i_REQ_ADDR1 : i_REQ_ADDR0;
  wire [23:0] pick_wdata = (pick == 2'd2) ? i_REQ_WDATA2 : (pick == 2'd1) ? i_REQ_WDATA1 : i_REQ_WDATA0;
  wire pick_w24 = i_REQ_W24[pick] || (i_REQ_SECOND_GEN[pick] && bridge_stat[`BRG_W24_BIT]);
  wire space_t pick_space = decode_space(pick_addr, i_REQ_SECOND_GEN[pick], bridge_stat);
  // beats: 16-bit word on 8-bit bus = 2, 24-bit = 3 bytes; 16-bit bus = 1 or 2
  wire [1:0] pick_last = bus16 ? (pick_w24 ? 2'd1 : 2'd0) : (pick_w24 ? 2'd2 : 2'd1);
  // word address to byte address; on the 8-bit bus 24-bit words pack into 4-byte slots
  wire [23:0] pick_byte = bus16 ? {pick_addr[22:0], 1'b0} : (pick_w24 ? {pick_addr[21:0], 2'b00} :
                          {pick_addr[22:0], 1'b0});

  wire [15:0] cur_ctl = space_ctl(space, bank_space_access_control, boot_space_access_control,
                                  io_space_access_control);
  wire [3:0] waits = acc_write ? cur_ctl[`ACC_WRW_LSB +: 4] : cur_ctl[`ACC_RDW_LSB +: 4];
  wire tick;

  space_clock_div u_div (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_run(busy),
    .i_div(cur_ctl[`ACC_DIV_LSB +: 2]),
    .o_tick(tick)
  );

  // transfer sequencer
  // wait mode is stored only; the strobe lasts wait count + 1 ticks of the divided space clock
  wire strobe_end = tick && wait_cnt == waits;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: next_state = (req_live != 3'b000) ? ST_SETUP : ST_IDLE;
      ST_SETUP: next_state = tick ? ST_STROBE : ST_SETUP;
      ST_STROBE: next_state = strobe_end ? ST_NEXT : ST_STROBE;
      ST_NEXT: next_state = tick ? ((beat == last_beat) ? ST_IDLE : ST_SETUP) : ST_NEXT;
    endcase
  end

  // data input synchroniser: compare second and third stage only
  always_ff @(posedge I_CORE_CLK) begin
    din_s1 <= i_EXT_DATA;
    din_s2 <= din_s1;
    din_s3 <= din_s2;
    if (din_s2 == din_s3) begin
      din_q <= din_s3;
    end
  end
  wire [15:0] din = din_q;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      state <= ST_IDLE;
      space <= SP_BANK;
      grant <= 2'd0;
      acc_write <= 1'b0;
      acc_w24 <= 1'b0;
      byte_addr <= 24'h000000;
      wdata <= 24'h000000;
      rdata <= 24'h000000;
      beat <= 2'd0;
      last_beat <= 2'd0;
      wait_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && req_live != 3'b000) begin
        grant <= pick;
        space <= pick_space;
        acc_write <= i_REQ_WRITE[pick];
        acc_w24 <= pick_w24;
        byte_addr <= pick_byte;
        wdata <= pick_wdata;
        beat <= 2'd0;
        last_beat <= pick_last;
        wait_cnt <= 4'h0;
      end
      if (state == ST_STROBE && tick && !strobe_end) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
      // capture at strobe end: bytes ascend, first byte is the lowest
      if (state == ST_STROBE && strobe_end && !acc_write) begin
        if (bus16) begin
          rdata <= beat == 2'd0 ? {8'h00, din} : {din[7:0], rdata[15:0]};
        end else begin
          rdata <= {din[7:0], rdata[23:8]};
        end
      end
      if (state == ST_NEXT && tick && beat != last_beat) begin
        beat <= beat + 2'd1;
        byte_addr <= byte_addr + (bus16 ? 24'h000002 : 24'h000001);
        wait_cnt <= 4'h0;
      end
    end
  end

  // completion and unpacking of read data
  wire finish = state == ST_NEXT && tick && beat == last_beat;
  wire [23:0] rd_aligned = bus16 ? rdata : (acc_w24 ? rdata : {8'h00, rdata[23:8]});
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      o_REQ_DONE <= 3'b000;
      o_RDATA_HIGH <= 16'h0000;
      bus_exchange_reg <= 8'h00;
    end else begin
      o_REQ_DONE <= finish ? (3'b001 << grant) : 3'b000;
      if (finish && !acc_write) begin
        if (acc_w24) begin
          bus_exchange_reg <= rd_aligned[7:0];
          o_RDATA_HIGH <= rd_aligned[23:8];
        end else begin
          o_RDATA_HIGH <= rd_aligned[15:0];
        end
      end
    end
  end
  assign o_BUS_EXCHANGE = bus_exchange_reg;

  // pins: selects track address and drop when idle
  wire strobe_on = state == ST_STROBE;
  wire [7:0] wr_byte = (beat == 2'd0) ? wdata[7:0] : (beat == 2'd1) ? wdata[15:8] : wdata[23:16];
  wire [15:0] wr_word = (beat == 2'd0) ? wdata[15:0] : {8'h00, wdata[23:16]};
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      o_EXT_ADDR <= 24'h000000;
      o_EXT_DATA <= 16'h0000;
      o_EXT_DATA_OE <= 1'b0;
      o_RD_STROBE <= 1'b0;
      o_WR_STROBE <= 1'b0;
      o_BOOT_SPACE_SELECT_N <= 1'b1;
      o_BANK_SELECT_N <= 1'b1;
      o_IO_SELECT_N <= 1'b1;
      o_COMMON_SELECT_OUTPUT <= 1'b0;
    end else begin
      o_EXT_ADDR <= byte_addr;
      o_EXT_DATA <= bus16 ? wr_word : {8'h00, wr_byte};
      o_EXT_DATA_OE <= busy && acc_write;
      // one polarity pair for all spaces
      o_RD_STROBE <= (strobe_on && !acc_write) ^ ext_mem_if_control[`EMI_RD_NEG_BIT];
      o_WR_STROBE <= (strobe_on && acc_write) ^ ext_mem_if_control[`EMI_WR_NEG_BIT];
      o_BOOT_SPACE_SELECT_N <= !(busy && space == SP_BOOT);
      o_BANK_SELECT_N <= !(busy && space == SP_BANK);
      o_IO_SELECT_N <= !(busy && space == SP_IO);
      o_COMMON_SELECT_OUTPUT <= busy && cur_ctl[`ACC_CMS_BIT];
    end
  end

  // assertions
  a_lock_blocks_boot: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (i_AVS_WRITE && i_AVS_ADDRESS == `OFS_BOOT_CTL && locked) |=> $stable(boot_space_access_control))
    else $error("boot control changed while locked");
  a_busy_keeps_size: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (wr_emi && busy) |=> $stable(ext_mem_if_control[`EMI_BUS16_BIT]))
    else $error("bus size changed during access");
  a_idle_selects_off: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (!busy) |=> (o_BANK_SELECT_N && o_IO_SELECT_N && o_BOOT_SPACE_SELECT_N))
    else $error("select active while idle");
  a_strobe_polarity: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (!busy && !$past(busy)) |-> (o_RD_STROBE == ext_mem_if_control[`EMI_RD_NEG_BIT] || $changed(ext_mem_if_control)))
    else $error("read strobe not at idle level");
  a_second_gen_boot: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (state == ST_IDLE && i_REQ == 3'b010 && i_REQ_SECOND_GEN[1] && bridge_stat[1] && bridge_stat[3])
    |=> space == SP_BOOT)
    else $error("second generator access not in boot space");
  a_done_after_last: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (o_REQ_DONE != 3'b000) |-> $past(beat == last_beat))
    else $error("done before last byte");
  a_byte_ascend: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (state == ST_NEXT && tick && beat != last_beat && !bus16) |=> byte_addr == $past(byte_addr) + 24'h000001)
    else $error("byte address not ascending");
  a_exchange_low: assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (finish && !acc_write && acc_w24) |=> bus_exchange_reg == $past(rd_aligned[7:0]))
    else $error("exchange byte wrong");
endmodule : boot_space_external_port

// *** sim/ext_mem_model.sv ***
/*
  behavioural asynchronous byte-wide or halfword-wide memory on the external pins.
  assumes the bench tells it the strobe sense and bus width; the data lines have no pull.
*/
module ext_mem_model (
  // clock
  input wire logic i_clk,
  // pins
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_sel_n,
  // settings mirrored from the bench
  input wire logic i_rd_neg,
  input wire logic i_wr_neg,
  input wire logic i_bus16,
  // data toward the port
  output logic [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [15:0] held;
  logic [2:0] hold_cnt;
  wire rd_on = (i_rd ^ i_rd_neg) && !i_sel_n;
  wire wr_on = (i_wr ^ i_wr_neg) && !i_sel_n;
  wire [15:0] live = {mem[8'(i_addr + 24'h000001)], mem[i_addr[7:0]]};

  // known fill so the bench can predict every byte
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
    held = 16'h0000;
    hold_cnt = 3'h0;
  end

  // data held four cycles past the strobe, then toggled so stale bytes never pass
  always @(posedge i_clk) begin
    if (rd_on) begin
      held <= live;
      hold_cnt <= 3'h3;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end else begin
      held <= ~held;
    end
    if (wr_on) begin
      mem[i_addr[7:0]] <= i_wdata[7:0];
      if (i_bus16) begin
        mem[8'(i_addr + 24'h000001)] <= i_wdata[15:8];
      end
    end
  end

  assign o_rdata = rd_on ? live : held;
endmodule : ext_mem_model

// *** sim/boot_space_external_port_tb.sv ***
/*
  self-checking bench of the boot-space external port.
  assumes ext_mem_model on the pins and the register map of ext_port_regs.svh.
*/
`include "ext_port_regs.svh"

module boot_space_external_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] av_addr = 6'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h00000000;
  logic [31:0] av_rdata;
  logic av_wait;
  logic [2:0] req = 3'h0;
  logic [2:0] req_wr = 3'h0;
  logic [2:0] req_w24 = 3'h0;
  logic [2:0] req_sg = 3'h0;
  logic [23:0] ra [3] = '{default: 24'h000000};
  logic [23:0] wd [3] = '{default: 24'h000000};
  logic [2:0] done;
  logic [15:0] rhigh, ext_din, ext_dout;
  logic [7:0] xchg;
  logic [23:0] ext_addr;
  logic ext_oe, rd_s, wr_s, boot_n, bank_n, io_n, common_select_output;
  logic rd_neg = 1'b0;
  logic wr_neg = 1'b0;
  logic bus16 = 1'b0;
  logic act, act_prev = 1'b0;
  logic boot_seen, bank_seen, cms_seen, oe_seen;
  logic [23:0] addrs [$];
  int failures = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  boot_space_external_port boot_space_external_port_inst (
    .I_CORE_CLK(clk), .I_SRST(srst),
    .i_AVS_ADDRESS(av_addr), .i_AVS_READ(av_rd), .i_AVS_WRITE(av_wr),
    .i_AVS_WRITEDATA(av_wdata), .i_AVS_BYTEENABLE(4'hF),
    .o_AVS_READDATA(av_rdata), .o_AVS_WAITREQUEST(av_wait),
    .i_REQ(req), .i_REQ_WRITE(req_wr), .i_REQ_W24(req_w24), .i_REQ_SECOND_GEN(req_sg),
    .i_REQ_ADDR0(ra[0]), .i_REQ_ADDR1(ra[1]), .i_REQ_ADDR2(ra[2]),
    .i_REQ_WDATA0(wd[0]), .i_REQ_WDATA1(wd[1]), .i_REQ_WDATA2(wd[2]),
    .o_REQ_DONE(done), .o_RDATA_HIGH(rhigh), .o_BUS_EXCHANGE(xchg),
    .o_EXT_ADDR(ext_addr), .i_EXT_DATA(ext_din), .o_EXT_DATA(ext_dout), .o_EXT_DATA_OE(ext_oe),
    .o_RD_STROBE(rd_s), .o_WR_STROBE(wr_s), .o_BOOT_SPACE_SELECT_N(boot_n),
    .o_BANK_SELECT_N(bank_n), .o_IO_SELECT_N(io_n), .o_COMMON_SELECT_OUTPUT(common_select_output));

  ext_mem_model ext_mem_model_inst (
    .i_clk(clk), .i_addr(ext_addr), .i_wdata(ext_dout), .i_rd(rd_s), .i_wr(wr_s),
    .i_sel_n(boot_n & bank_n & io_n), .i_rd_neg(rd_neg), .i_wr_neg(wr_neg),
    .i_bus16(bus16), .o_rdata(ext_din));

  // strobe starts as the far side sees them, logged for order and select checks
  always @(negedge clk) begin
    act = (rd_s ^ rd_neg) | (wr_s ^ wr_neg);
    if (act && !act_prev) addrs.push_back(ext_addr);
    if (act && !boot_n) boot_seen = 1'b1;
    if (act && !bank_n) bank_seen = 1'b1;
    if (act && common_select_output) cms_seen = 1'b1;
    if (act && ext_oe) oe_seen = 1'b1;
    act_prev = act;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus_wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    av_addr <= a;
    av_wdata <= {16'h0000, d};
    av_wr <= 1'b1;
    do @(posedge clk); while (av_wait !== 1'b0);
    av_wr <= 1'b0;
  endtask : bus_wr

  // read data is taken at the edge where waitrequest is seen low
  task automatic bus_rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    av_addr <= a;
    av_rd <= 1'b1;
    do @(posedge clk); while (av_wait !== 1'b0);
    d = av_rdata[15:0];
    av_rd <= 1'b0;
  endtask : bus_rd

  task automatic xfer(input int k, input logic w, input logic w24, input logic [23:0] a, input logic [23:0] d);
    int n;
    addrs.delete();
    boot_seen = 1'b0;
    bank_seen = 1'b0;
    cms_seen = 1'b0;
    oe_seen = 1'b0;
    @(posedge clk);
    req_wr[k] <= w;
    req_w24[k] <= w24;
    req_sg[k] <= w24;
    ra[k] <= a;
    wd[k] <= d;
    req[k] <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done[k] !== 1'b1 && n < 2000);
    if (n >= 2000) chk("done timeout", 1, 0);
    @(posedge clk);
    req[k] <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : xfer

  task automatic t_regs();
    logic [15:0] v;
    bus_rd(`OFS_EMI_CTL, v);
    chk("ctl reset", `EMI_CTL_RST, v);
    bus_rd(`OFS_BOOT_CTL, v);
    chk("boot reset", `ACC_CTL_RST, v);
    bus_wr(`OFS_BOOT_CTL, 16'h0DFF);
    bus_wr(`OFS_BANK_CTL, 16'h02F5);
    bus_wr(`OFS_IO_CTL, 16'h0003);
    bus_wr(6'h3C, 16'hFFFF);
    bus_rd(`OFS_BOOT_CTL, v);
    chk("boot ctl", 16'h0DFF, v);
    bus_rd(`OFS_BANK_CTL, v);
    chk("bank ctl", 16'h02F5, v);
    bus_rd(`OFS_IO_CTL, v);
    chk("io ctl", 16'h0003, v);
  endtask : t_regs

  // 8-bit bus with low-active strobes, 24-bit packing through the second generator
  task automatic t_boot24();
    bus_wr(`OFS_EMI_CTL, 16'h0030);
    rd_neg <= 1'b1;
    wr_neg <= 1'b1;
    bus_wr(`OFS_BRIDGE_STAT, 16'h000A);
    repeat (2) @(negedge clk);
    chk("rd idle", 1, rd_s);
    chk("wr idle", 1, wr_s);
    xfer(1, 1'b0, 1'b1, 24'h000009, 24'h000000);
    chk("bytes", 3, addrs.size());
    foreach (addrs[i]) chk("byte addr", 24'h000024 + i, addrs[i]);
    chk("boot sel", 1, boot_seen);
    chk("bank sel", 0, bank_seen);
    chk("cms off", 0, cms_seen);
    chk("oe on read", 0, oe_seen);
    chk("exchange", 8'h24 ^ 8'hA5, xchg);
    chk("high", {8'h26 ^ 8'hA5, 8'h25 ^ 8'hA5}, rhigh);
    chk("idle sel", 3'b111, {boot_n, bank_n, io_n});
    xfer(2, 1'b0, 1'b0, 24'h800003, 24'h000000);
    chk("boot page", 1, boot_seen);
    chk("packed", {8'h07 ^ 8'hA5, 8'h06 ^ 8'hA5}, rhigh);
  endtask : t_boot24

  // 16-bit bus, high-active strobes, size change tried during an access
  task automatic t_dma16();
    logic [15:0] v;
    bus_wr(`OFS_BANK_CTL, 16'h12F5);
    bus_wr(`OFS_EMI_CTL, 16'h0001);
    rd_neg <= 1'b0;
    wr_neg <= 1'b0;
    bus16 <= 1'b1;
    fork
      xfer(2, 1'b1, 1'b0, 24'h000010, 24'h00BEEF);
      begin
        repeat (4) @(posedge clk);
        bus_wr(`OFS_EMI_CTL, 16'h0030);
      end
    join
    chk("bank write", 1, bank_seen);
    chk("boot write", 0, boot_seen);
    chk("cms on", 1, cms_seen);
    chk("oe on write", 1, oe_seen);
    bus_rd(`OFS_EMI_CTL, v);
    chk("ctl busy", 16'h0001, v);
    xfer(0, 1'b0, 1'b0, 24'h000010, 24'h000000);
    chk("readback", 16'hBEEF, rhigh);
  endtask : t_dma16

  task automatic t_lock();
    logic [15:0] v;
    bus_wr(`OFS_EMI_CTL, 16'h0101);
    bus_wr(`OFS_BOOT_CTL, 16'h0000);
    bus_wr(`OFS_IO_CTL, 16'h0FFF);
    bus_wr(`OFS_EMI_CTL, 16'h0130);
    bus_rd(`OFS_BOOT_CTL, v);
    chk("boot locked", 16'h0DFF, v);
    bus_rd(`OFS_IO_CTL, v);
    chk("io locked", 16'h0003, v);
    bus_rd(`OFS_EMI_CTL, v);
    chk("ctl locked", 16'h0101, v);
  endtask : t_lock

  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // watchdog well beyond the few hundred cycles the transfers need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_boot24();
    t_dma16();
    t_lock();
    report_and_stop();
  end
endmodule : boot_space_external_port_tb
